//--- design/rdf_map.vh
// Function
// - two separate 64-entry byte buffers, receive and transmit
// - host reads receive buffer, writes transmit buffer
// - flag receive overflow and transmit underflow
// - status byte shows fill grade per access direction
// - expose stored byte count of each buffer
// - 4-bit threshold select, sixteen points, both buffers
// - rx threshold 4(v+1), tx threshold 61-4v
// - threshold signal when count reaches threshold
// - output select 0x00 rx, 0x02 tx threshold
`ifndef RDF_MAP_VH
`define RDF_MAP_VH
`define RDF_DEPTH          64
`define RDF_PTR_W          6
`define RDF_CNT_W          7
`define RDF_THR_W          4
`define RDF_SEL_W          6
`define RDF_SEL_RX_THR     6'h00
`define RDF_SEL_TX_THR     6'h02
`define RDF_TX_THR_BASE    7'h3D
`define RDF_THR_STEP_SH    2
`define RDF_LINK_FIFO_W    8
`define RDF_LINK_FIFO_D    32
`define RDF_FILL_SATURATE  4'hF
`endif

//--- design/rdf_link_fifo.v
`timescale 1ns/1ns
module rdf_link_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  // clock and reset
  input  wire             clock,
  input  wire             reset,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_ff;
  reg [AW-1:0]    rd_ptr_ff;
  reg [AW:0]      cnt_ff;
  wire            push;
  wire            pop;

  assign in_ready  = (cnt_ff != DEPTH[AW:0]);
  assign out_valid = (cnt_ff != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr_ff];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      cnt_ff    <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                     : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                     : rd_ptr_ff + 1'b1;
      end
      if (push & ~pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop & ~push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule // rdf_link_fifo

//--- design/rdf_fifo_pair.v
`timescale 1ns/1ns
`include "rdf_map.vh"
module rdf_fifo_pair #(
  parameter DEPTH = `RDF_DEPTH
) (
  // clock and reset
  input  wire                   clock,
  input  wire                   reset,
  // modem receive stream with its own bit clock, sampled on the system clock
  input  wire                   modem_rx_clk,
  input  wire                   modem_rx_valid,
  input  wire [7:0]             modem_rx_data,
  output wire                   modem_rx_ready,
  // modem transmit drain
  input  wire                   modem_tx_take,
  output reg  [7:0]             modem_tx_data_ff,
  // host side, one-cycle strobes
  input  wire                   host_rd_strobe,
  output reg  [7:0]             host_rd_data_ff,
  input  wire                   host_wr_strobe,
  input  wire [7:0]             host_wr_data,
  input  wire                   host_hdr_is_read,
  output reg  [3:0]             status_fill_ff,
  // status
  output reg  [`RDF_CNT_W-1:0]  rx_stored_byte_count,
  output reg  [`RDF_CNT_W-1:0]  tx_stored_byte_count,
  output reg                    rx_overflow_ff,
  output reg                    tx_underflow_ff,
  input  wire                   flag_clear,
  // threshold and general output
  input  wire [`RDF_THR_W-1:0]  buffer_threshold_select,
  input  wire [`RDF_SEL_W-1:0]  general_output_select,
  output reg                    general_output_pin
);
  ////////////////////////////////////////////////////////////////////////
  // storage
  reg [7:0]            rx_mem [0:DEPTH-1];
  reg [7:0]            tx_mem [0:DEPTH-1];
  reg [`RDF_PTR_W-1:0] rx_wp_ff;
  reg [`RDF_PTR_W-1:0] rx_rp_ff;
  reg [`RDF_PTR_W-1:0] tx_wp_ff;
  reg [`RDF_PTR_W-1:0] tx_rp_ff;
  reg                  clk_s1_ff;
  reg                  clk_s2_ff;
  reg                  clk_s3_ff;
  reg                  val_s1_ff;
  reg                  val_s2_ff;
  reg [7:0]            dat_s1_ff;
  reg [7:0]            dat_s2_ff;
  wire                 link_rise;
  wire                 link_valid;
  wire                 link_ready;
  wire                 q_valid;
  wire [7:0]           q_data;
  wire                 rx_store;
  wire                 rx_full;
  wire                 rx_empty;
  wire                 rx_take;
  wire                 tx_store;
  wire                 tx_take;
  wire                 tx_full;
  wire                 tx_empty;
  wire [`RDF_CNT_W-1:0] rx_thr;
  wire [`RDF_CNT_W-1:0] tx_thr;
  wire                 rx_thr_hit;
  wire                 tx_thr_hit;
  wire [`RDF_CNT_W-1:0] nxt_rx_count;
  wire [`RDF_CNT_W-1:0] nxt_tx_count;
  reg  [3:0]           nxt_status_fill;
  reg                  nxt_output_pin;
  reg                  nxt_rx_overflow;
  reg                  nxt_tx_underflow;

  function [`RDF_PTR_W-1:0] ptr_inc;
    input [`RDF_PTR_W-1:0] p;
    begin
      ptr_inc = (p == DEPTH[`RDF_PTR_W-1:0] - 1'b1) ? {`RDF_PTR_W{1'b0}}
                : p + 1'b1;
    end
  endfunction

  function [`RDF_CNT_W-1:0] cnt_next;
    input [`RDF_CNT_W-1:0] c;
    input                  up;
    input                  dn;
    begin
      if (up & ~dn) begin
        cnt_next = c + 1'b1;
      end else if (dn & ~up) begin
        cnt_next = c - 1'b1;
      end else begin
        cnt_next = c;
      end
    end
  endfunction

  function [3:0] fill_grade;
    input [`RDF_CNT_W-1:0] c;
    begin
      fill_grade = (c > 7'h0F) ? `RDF_FILL_SATURATE : c[3:0];
    end
  endfunction

  function buf_full;
    input [`RDF_CNT_W-1:0] c;
    begin
      buf_full = (c == DEPTH[`RDF_CNT_W-1:0]);
    end
  endfunction

  function buf_empty;
    input [`RDF_CNT_W-1:0] c;
    begin
      buf_empty = (c == {`RDF_CNT_W{1'b0}});
    end
  endfunction

  // shared by both thresholds
  function at_or_above;
    input [`RDF_CNT_W-1:0] c;
    input [`RDF_CNT_W-1:0] t;
    begin
      at_or_above = (c >= t);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // modem receive input: two flip-flops before any logic reads it
  always @(posedge clock) begin
    if (reset) begin
      clk_s1_ff <= 1'b0;
      clk_s2_ff <= 1'b0;
      clk_s3_ff <= 1'b0;
      val_s1_ff <= 1'b0;
      val_s2_ff <= 1'b0;
      dat_s1_ff <= 8'h00;
      dat_s2_ff <= 8'h00;
    end else begin
      clk_s1_ff <= modem_rx_clk;
      clk_s2_ff <= clk_s1_ff;
      clk_s3_ff <= clk_s2_ff;
      val_s1_ff <= modem_rx_valid;
      val_s2_ff <= val_s1_ff;
      dat_s1_ff <= modem_rx_data;
      dat_s2_ff <= dat_s1_ff;
    end
  end

  // data is stable around the rising link edge, so the synced copy is safe
  assign link_rise      = clk_s2_ff & ~clk_s3_ff;
  assign link_valid     = link_rise & val_s2_ff;
  assign modem_rx_ready = link_ready;

  rdf_link_fifo #(
    .WIDTH (`RDF_LINK_FIFO_W),
    .DEPTH (`RDF_LINK_FIFO_D),
    .AW    (5)
  ) u_link_fifo (
    .clock     (clock),
    .reset     (reset),
    .in_valid  (link_valid),
    .in_ready  (link_ready),
    .in_data   (dat_s2_ff),
    .out_valid (q_valid),
    .out_ready (1'b1),
    .out_data  (q_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // receive buffer: modem fills, host drains
  assign rx_full  = buf_full(rx_stored_byte_count);
  assign rx_empty = buf_empty(rx_stored_byte_count);
  assign rx_store = q_valid & ~rx_full;
  // reading past empty returns the stale byte, nothing moves
  assign rx_take  = host_rd_strobe & ~rx_empty;
  assign nxt_rx_count = cnt_next(rx_stored_byte_count,
                                 rx_store, rx_take);

  // set wins over clear when both land in one cycle
  always @* begin
    if (q_valid & rx_full) begin
      nxt_rx_overflow = 1'b1;
    end else if (flag_clear) begin
      nxt_rx_overflow = 1'b0;
    end else begin
      nxt_rx_overflow = rx_overflow_ff;
    end
  end

  always @(posedge clock) begin
    if (rx_store) begin
      rx_mem[rx_wp_ff] <= q_data;
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      rx_wp_ff             <= {`RDF_PTR_W{1'b0}};
      rx_rp_ff             <= {`RDF_PTR_W{1'b0}};
      rx_stored_byte_count <= {`RDF_CNT_W{1'b0}};
      host_rd_data_ff      <= 8'h00;
      rx_overflow_ff       <= 1'b0;
    end else begin
      if (rx_store) begin
        rx_wp_ff <= ptr_inc(rx_wp_ff);
      end
      if (host_rd_strobe) begin
        host_rd_data_ff <= rx_mem[rx_rp_ff];
      end
      if (rx_take) begin
        rx_rp_ff <= ptr_inc(rx_rp_ff);
      end
      rx_stored_byte_count <= nxt_rx_count;
      rx_overflow_ff       <= nxt_rx_overflow;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit buffer: host fills, modem drains
  assign tx_full  = buf_full(tx_stored_byte_count);
  assign tx_empty = buf_empty(tx_stored_byte_count);
  // writes into a full buffer are dropped rather than overwriting
  assign tx_store = host_wr_strobe & ~tx_full;
  assign tx_take  = modem_tx_take & ~tx_empty;
  assign nxt_tx_count = cnt_next(tx_stored_byte_count,
                                 tx_store, tx_take);

  // underflow is sticky until cleared; set wins over clear
  always @* begin
    if (modem_tx_take & tx_empty) begin
      nxt_tx_underflow = 1'b1;
    end else if (flag_clear) begin
      nxt_tx_underflow = 1'b0;
    end else begin
      nxt_tx_underflow = tx_underflow_ff;
    end
  end

  always @(posedge clock) begin
    if (tx_store) begin
      tx_mem[tx_wp_ff] <= host_wr_data;
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      tx_wp_ff             <= {`RDF_PTR_W{1'b0}};
      tx_rp_ff             <= {`RDF_PTR_W{1'b0}};
      tx_stored_byte_count <= {`RDF_CNT_W{1'b0}};
      modem_tx_data_ff     <= 8'h00;
      tx_underflow_ff      <= 1'b0;
    end else begin
      if (tx_store) begin
        tx_wp_ff <= ptr_inc(tx_wp_ff);
      end
      if (tx_take) begin
        modem_tx_data_ff <= tx_mem[tx_rp_ff];
        tx_rp_ff         <= ptr_inc(tx_rp_ff);
      end
      tx_stored_byte_count <= nxt_tx_count;
      tx_underflow_ff      <= nxt_tx_underflow;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status byte fill grade and threshold output
  assign rx_thr = {1'b0, buffer_threshold_select, 2'b00}
                  + 7'h04;
  assign tx_thr = `RDF_TX_THR_BASE
                  - {1'b0, buffer_threshold_select, 2'b00};
  assign rx_thr_hit = at_or_above(rx_stored_byte_count, rx_thr);
  assign tx_thr_hit = at_or_above(tx_stored_byte_count, tx_thr);

  // the header direction picks which buffer the status byte describes
  always @* begin
    if (host_hdr_is_read) begin
      nxt_status_fill = fill_grade(rx_stored_byte_count);
    end else begin
      nxt_status_fill = fill_grade(tx_stored_byte_count);
    end
  end

  // unused select codes hold the pin low instead of leaving it stale
  always @* begin
    case (general_output_select)
      `RDF_SEL_RX_THR: nxt_output_pin = rx_thr_hit;
      `RDF_SEL_TX_THR: nxt_output_pin = tx_thr_hit;
      default:         nxt_output_pin = 1'b0;
    endcase
  end

  // the compare runs every cycle, so the pin drops with the count
  always @(posedge clock) begin
    if (reset) begin
      status_fill_ff     <= 4'h0;
      general_output_pin <= 1'b0;
    end else begin
      status_fill_ff     <= nxt_status_fill;
      general_output_pin <= nxt_output_pin;
    end
  end
endmodule // rdf_fifo_pair

//--- testbench/rdf_link_src.sv
`timescale 1ns/1ns
module rdf_link_src (
  // link pins toward the block
  output logic       modem_rx_clk,
  output logic       modem_rx_valid,
  output logic [7:0] modem_rx_data
);
  initial begin
    modem_rx_clk = 1'b0;
    modem_rx_valid = 1'b0;
    modem_rx_data = 8'h00;
  end
  // one byte per 320 ns link period; the link clock rests low between bytes
  task automatic send(input logic [7:0] d);
    modem_rx_valid = 1'b1;
    modem_rx_data = d;
    #160 modem_rx_clk = 1'b1;
    // the block has taken the byte two system clocks after the rise
    #80 modem_rx_valid = 1'b0;
    // data is not held after the frame, so show the inverse
    modem_rx_data = ~d;
    #80 modem_rx_clk = 1'b0;
  endtask
endmodule // rdf_link_src

//--- testbench/rdf_fifo_pair_chk.sv
`timescale 1ns/1ns
module rdf_fifo_pair_chk (
  // clock and reset
  input wire       clock,
  input wire       reset,
  // strobes
  input wire       host_wr_strobe,
  input wire       host_hdr_is_read,
  input wire       modem_tx_take,
  input wire       flag_clear,
  // status and pin
  input wire [3:0] status_fill_ff,
  input wire [6:0] rx_stored_byte_count,
  input wire [6:0] tx_stored_byte_count,
  input wire       rx_overflow_ff,
  input wire       tx_underflow_ff,
  input wire [3:0] buffer_threshold_select,
  input wire [5:0] general_output_select,
  input wire       general_output_pin
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  wire [6:0] rxc = rx_stored_byte_count;
  wire [6:0] txc = tx_stored_byte_count;
  wire [6:0] st4 = {1'b0, buffer_threshold_select, 2'b00};
  wire [5:0] sel = general_output_select;
  wire       wr  = host_wr_strobe;
  wire       tk  = modem_tx_take;
  //////////////////////////////////////////////////////////////////////////
  depth_bound_a: assert property (
    rxc <= 7'h40 && txc <= 7'h40) else $error("count above depth");
  tx_store_a: assert property (
    wr && !tk && txc < 7'h40 |=> txc == $past(txc) + 7'h01)
    else $error("tx store not counted");
  tx_take_a: assert property (
    tk && !wr && txc != 7'h00 |=> txc == $past(txc) - 7'h01)
    else $error("tx take not counted");
  tx_both_a: assert property (
    wr && tk && txc != 7'h00 && txc != 7'h40 |=> $stable(txc))
    else $error("tx count moved on store and take");
  tx_under_a: assert property (
    tk && txc == 7'h00 |=> tx_underflow_ff) else $error("underflow missed");
  flag_clear_a: assert property (
    flag_clear && !tk |=> !tx_underflow_ff) else $error("flag not cleared");
  ovf_cause_a: assert property (
    $rose(rx_overflow_ff) |-> $past(rxc) == 7'h40)
    else $error("overflow without full buffer");
  fill_grade_a: assert property (
    host_hdr_is_read |=> status_fill_ff ==
      ($past(rxc) > 7'h0F ? 4'hF : $past(rxc[3:0])))
    else $error("rx fill grade wrong");
  rx_thr_pin_a: assert property (
    sel == 6'h00 |=> general_output_pin == ($past(rxc) >= $past(st4) + 7'h04))
    else $error("rx threshold pin wrong");
  tx_thr_pin_a: assert property (
    sel == 6'h02 |=> general_output_pin == ($past(txc) >= 7'h3D - $past(st4)))
    else $error("tx threshold pin wrong");
  pin_off_a: assert property (
    sel != 6'h00 && sel != 6'h02 |=> !general_output_pin)
    else $error("pin driven by other select");
endmodule // rdf_fifo_pair_chk

bind rdf_fifo_pair rdf_fifo_pair_chk rdf_fifo_pair_chk_i (
  .clock(clock), .reset(reset), .host_wr_strobe(host_wr_strobe),
  .host_hdr_is_read(host_hdr_is_read), .modem_tx_take(modem_tx_take),
  .flag_clear(flag_clear), .status_fill_ff(status_fill_ff),
  .rx_stored_byte_count(rx_stored_byte_count),
  .tx_stored_byte_count(tx_stored_byte_count),
  .rx_overflow_ff(rx_overflow_ff), .tx_underflow_ff(tx_underflow_ff),
  .buffer_threshold_select(buffer_threshold_select),
  .general_output_select(general_output_select),
  .general_output_pin(general_output_pin));

//--- testbench/radio_data_fifo_pair_tb.sv
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module radio_data_fifo_pair_tb;
  // stimulus
  logic        clock, reset, take, rd, wr, hdr_rd, clr;
  logic  [7:0] wdata;
  logic  [3:0] thr;
  logic  [5:0] gsel;
  logic [31:0] r;
  // observed
  wire         lclk, lvalid, lready, pin, ovf, unf;
  wire   [7:0] ldata, txd, rdd;
  wire   [3:0] fill;
  wire   [6:0] rxc, txc;
  int          mismatches, n_checks, cyc, seed = 39;
  logic  [7:0] txq[$], rxq[$];
  //////////////////////////////////////////////////////////////////////////
  rdf_link_src rdf_link_src_i (.modem_rx_clk(lclk), .modem_rx_valid(lvalid),
    .modem_rx_data(ldata));
  rdf_fifo_pair rdf_fifo_pair_i (.clock(clock), .reset(reset),
    .modem_rx_clk(lclk), .modem_rx_valid(lvalid), .modem_rx_data(ldata),
    .modem_rx_ready(lready), .modem_tx_take(take), .modem_tx_data_ff(txd),
    .host_rd_strobe(rd), .host_rd_data_ff(rdd), .host_wr_strobe(wr),
    .host_wr_data(wdata), .host_hdr_is_read(hdr_rd), .status_fill_ff(fill),
    .rx_stored_byte_count(rxc), .tx_stored_byte_count(txc),
    .rx_overflow_ff(ovf), .tx_underflow_ff(unf), .flag_clear(clr),
    .buffer_threshold_select(thr), .general_output_select(gsel),
    .general_output_pin(pin));
  //////////////////////////////////////////////////////////////////////////
  function logic exp_pin(input int c, input logic [3:0] v,
                         input logic [5:0] s);
    if (s == 6'h00) return c >= 4 * (v + 1);
    if (s == 6'h02) return c >= 61 - 4 * v;
    return 1'b0;
  endfunction
  function logic [3:0] sat(input int c);
    return c > 15 ? 4'hF : 4'(c);
  endfunction
  task step; @(posedge clock); #2; endtask
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one host write, host read or modem take, or a write and take together, then the counts, fill grade and pin are compared
  task automatic op(input logic w, rq, t, input logic [7:0] d);
    logic [7:0] e;
    r = $random(seed);
    thr = r[3:0];
    gsel = {3'h0, r[5:4] == 2'b11, r[5], 1'b0};
    {wr, rd, take, hdr_rd, wdata} = {w, rq, t, rq, d};
    step;
    {wr, rd, take, wdata} = {3'b000, ~d};
    step;
    if (t && txq.size() == 0) `CHK(unf, 1'b1)
    else if (t) begin
      e = txq.pop_front();
      `CHK(txd, e)
    end
    if (w && txq.size() < 64) txq.push_back(d);
    if (rq && rxq.size() > 0) begin
      e = rxq.pop_front();
      `CHK(rdd, e)
    end
    `CHK(txc, 7'(txq.size()))
    `CHK(rxc, 7'(rxq.size()))
    `CHK(fill, sat(rq ? rxq.size() : txq.size()))
    `CHK(pin, exp_pin(gsel == 6'h00 ? rxq.size() : txq.size(), thr, gsel))
  endtask
  task clear;
    clr = 1'b1;
    step;
    clr = 1'b0;
    step;
    `CHK({ovf, unf}, 2'b00)
  endtask
  // bytes beyond the depth are lost, so the queue stops at 64
  task send_rx;
    r = $random(seed);
    if (rxq.size() < 64) rxq.push_back(r[7:0]);
    rdf_link_src_i.send(r[7:0]);
  endtask
  task automatic wait_rx(input int n);
    for (int i = 0; i < 80 && rxc !== 7'(n); i++) step;
    `CHK(rxc, 7'(n))
  endtask
  task rd_byte;
    logic [7:0] e;
    {rd, hdr_rd} = 2'b11;
    step;
    rd = 1'b0;
    step;
    e = rxq.pop_front();
    `CHK(rdd, e)
  endtask
  // poll until two counts agree, keep one byte back until the packet is in
  task automatic poll_read(input int total);
    int n, m;
    while (total > 0) begin
      m = -1;
      n = rxc;
      while (n != m) begin
        m = n;
        repeat (3) step;
        n = rxc;
      end
      if (n < total && n > 0) n = n - 1;
      total -= n;
      repeat (n) rd_byte;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 8000) begin
      mismatches++;
      test_done;
    end
  end
  initial begin
    {reset, take, rd, wr, hdr_rd, clr} = 6'b100000;
    {wdata, thr, gsel} = 18'h0;
    repeat (4) @(posedge clock);
    #2 reset = 1'b0;
    step;
    `CHK(lready, 1'b1)
    wr = 1'b1;
    for (int i = 0; i < 8; i++) begin
      wdata = $random(seed);
      txq.push_back(wdata);
      step;
    end
    wr = 1'b0;
    step;
    `CHK(txc, 7'h08)
    repeat (300) begin
      r = $random(seed);
      if (r[0] && r[1] && (txq.size() == 0 || txq.size() == 64)) r[1] = 1'b0;
      op(r[0], 1'b0, r[1], r[15:8]);
    end
    while (txq.size() < 64) op(1'b1, 1'b0, 1'b0, 8'($random(seed)));
    op(1'b1, 1'b0, 1'b0, 8'hA5);
    repeat (65) op(1'b0, 1'b0, 1'b1, 8'h00);
    clear;
    // whole packet lands before the host starts reading
    repeat (10) send_rx;
    wait_rx(10);
    repeat (11) op(1'b0, 1'b1, 1'b0, 8'h00);
    repeat (66) send_rx;
    wait_rx(64);
    repeat (20) step;
    `CHK({ovf, rxc}, 8'hC0)
    clear;
    repeat (64) op(1'b0, 1'b1, 1'b0, 8'h00);
    // long packet drained while it still arrives
    fork
      repeat (70) send_rx;
      poll_read(70);
    join
    `CHK(rxc, 7'h00)
    test_done;
  end
endmodule // radio_data_fifo_pair_tb
